// ==== src/dmc_pkg.sv ====
// constants for the memory-device mode configuration block
// assumes a 10 MHz system clock sampling all memory pins
package dmc_pkg;

   // sampled pin vector layout
   localparam int P_CK   = 0;
   localparam int P_CKE  = 1;
   localparam int P_CS   = 2;
   localparam int P_RAS  = 3;
   localparam int P_CAS  = 4;
   localparam int P_WE   = 5;
   localparam int P_ODT  = 6;
   localparam int P_BA   = 7;
   localparam int P_ADDR = 10;
   localparam int PIN_W  = 26;

   // mode register select codes on the bank pins
   localparam logic [2:0] SEL_FIRST  = 3'h0;
   localparam logic [2:0] SEL_SECOND = 3'h1;
   localparam logic [2:0] SEL_THIRD  = 3'h2;

   // first mode register fields
   localparam int F_BL_LO    = 0;
   localparam int F_CL_LSB2  = 2;
   localparam int F_BTYPE    = 3;
   localparam int F_CL_LO    = 4;
   localparam int F_TEST     = 7;
   localparam int F_DLL_RST  = 8;
   localparam int F_WR_LO    = 9;
   localparam int F_PPD      = 12;

   // second mode register fields
   localparam int F_DLL_DIS  = 0;
   localparam int F_DIC0     = 1;
   localparam int F_RTT0     = 2;
   localparam int F_AL_LO    = 3;
   localparam int F_DIC1     = 5;
   localparam int F_RTT1     = 6;
   localparam int F_WRLVL    = 7;
   localparam int F_RTT2     = 9;
   localparam int F_TERMINATION_STROBE     = 11;
   localparam int F_QOFF     = 12;

   // third mode register fields
   localparam int F_CWL_LO   = 3;
   localparam int F_RTTWR_LO = 9;

   // burst length codes
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF    = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;

   // additive latency codes
   localparam logic [1:0] AL_ZERO  = 2'h0;
   localparam logic [1:0] AL_CLM1  = 2'h1;
   localparam logic [1:0] AL_CLM2  = 2'h2;

   // latency bases, in link clocks
   localparam logic [5:0] CL_BASE_LO  = 6'h04;
   localparam logic [5:0] CL_BASE_HI  = 6'h0C;
   localparam logic [5:0] CWL_BASE    = 6'h05;
   localparam logic [5:0] WR_INT_BL8  = 6'h04;
   localparam logic [5:0] WR_INT_BC4  = 6'h02;

   // default lock wait of the delay loop, in link clocks
   localparam int DLL_LOCK_CYCLES = 512;

   // register reset value
   localparam logic [15:0] MR_RESET = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_WAIT,
      ST_RD_BURST,
      ST_WR_WAIT,
      ST_WR_BURST
   } dmc_state_t;

endpackage

// ==== src/dmc_burst_order.sv ====
// beat index generator for one burst slot
// assumes start and slot come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module dmc_burst_order (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // burst description
   input  wire logic [2:0] start_i,
   input  wire logic       interleave_i,
   input  wire logic [2:0] slot_i,
   // beat index
   output logic      [2:0] beat_idx_o
);

   typedef struct packed {
      logic [2:0] idx;
   } dmc_bo_state_t;

   dmc_bo_state_t st_ff;
   dmc_bo_state_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (interleave_i) begin
         nxt_st.idx = start_i ^ slot_i;
      end else begin
         nxt_st.idx = {start_i[2] ^ slot_i[2], 2'(start_i[1:0] + slot_i[1:0])};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign beat_idx_o = st_ff.idx;

endmodule // dmc_burst_order
`default_nettype wire

// ==== src/dmc_mode_cfg.sv ====
// mode configuration, latency and burst sequencing of a memory device
// assumes all memory pins, link clock included, are asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module dmc_mode_cfg #(
   parameter int DLL_LOCK = dmc_pkg::DLL_LOCK_CYCLES
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // memory command pins
   input  wire logic        ck_i,
   input  wire logic        cke_i,
   input  wire logic        cs_n_i,
   input  wire logic        ras_n_i,
   input  wire logic        cas_n_i,
   input  wire logic        we_n_i,
   input  wire logic        termination_control_pin_i,
   input  wire logic [2:0]  ba_i,
   input  wire logic [15:0] addr_i,
   // data path sequencing
   output logic             beat_valid_o,
   output logic             beat_write_o,
   output logic [2:0]       beat_idx_o,
   output logic             dq_oe_n_o,
   output logic             internal_write_o,
   // termination and driver
   output logic             term_on_o,
   output logic             term_use_wr_o,
   output logic [2:0]       term_nom_code_o,
   output logic [1:0]       term_wr_code_o,
   output logic [1:0]       drive_imp_o,
   output logic             data_mask_en_o,
   // configuration state
   output logic             dll_run_o,
   output logic             dll_locked_o,
   output logic             slow_exit_o,
   output logic             write_level_o,
   output logic             test_mode_o,
   output logic [15:0]      mode_reg_first_o,
   output logic [15:0]      mode_reg_second_o,
   output logic [15:0]      mode_reg_third_o,
   output logic [5:0]       read_latency_o,
   output logic [5:0]       write_latency_o
);
   import dmc_pkg::*;

   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic             ck_prev;
      logic             cke_prev;
      logic [15:0]      mr0;
      logic [15:0]      mr1;
      logic [15:0]      mr2;
      dmc_state_t       st;
      logic [5:0]       lat;
      logic [3:0]       slot;
      logic [2:0]       start;
      logic             chop;
      logic [5:0]       wrc;
      logic             wr_int;
      logic [15:0]      dll_cnt;
      logic             dll_on;
      logic             locked;
      logic             sref;
      logic             pdn;
      logic             bvalid;
      logic             bwrite;
      logic             oe_n;
      logic             term_on;
      logic             term_wr;
   } dmc_cfg_state_t;

   dmc_cfg_state_t st_ff;
   dmc_cfg_state_t nxt_st;

   // read column latency from the first register
   function automatic logic [5:0] cl_of(input logic [15:0] mr);
      logic [5:0] v;
      v = {3'h0, mr[F_CL_LO+2:F_CL_LO]};
      cl_of = mr[F_CL_LSB2] ? 6'(CL_BASE_HI + v) : 6'(CL_BASE_LO + v);
   endfunction

   // additive latency from the second register
   function automatic logic [5:0] al_of(input logic [15:0] mr, input logic [5:0] cl);
      case (mr[F_AL_LO+1:F_AL_LO])
         AL_CLM1: al_of = 6'(cl - 6'h01);
         AL_CLM2: al_of = 6'(cl - 6'h02);
         default: al_of = 6'h00;
      endcase
   endfunction

   logic [PIN_W-1:0] pins;
   logic [5:0]       cl;
   logic [5:0]       al;
   logic [5:0]       rl;
   logic [5:0]       wl;
   logic [2:0]       rtt_nom;
   logic [1:0]       rtt_wr;
   logic             rise;
   logic             edge_any;
   logic             cmd_ok;
   logic             is_mrs;
   logic             is_rd;
   logic             is_wr;
   logic             is_sre;
   logic [15:0]      a;
   logic [2:0]       bo_slot;

   assign pins = {addr_i, ba_i, termination_control_pin_i, we_n_i, cas_n_i,
                  ras_n_i, cs_n_i, cke_i, ck_i};
   assign cl = cl_of(st_ff.mr0);
   assign al = al_of(st_ff.mr1, cl);
   assign rl = 6'(al + cl);
   assign wl = 6'(al + CWL_BASE + {3'h0, st_ff.mr2[F_CWL_LO+2:F_CWL_LO]});
   assign rtt_nom = {st_ff.mr1[F_RTT2], st_ff.mr1[F_RTT1], st_ff.mr1[F_RTT0]};
   assign rtt_wr = st_ff.mr2[F_RTTWR_LO+1:F_RTTWR_LO];
   assign a = st_ff.s2[P_ADDR+15:P_ADDR];
   assign rise = st_ff.s2[P_CK] & ~st_ff.ck_prev;
   assign edge_any = st_ff.s2[P_CK] ^ st_ff.ck_prev;
   assign cmd_ok = rise & st_ff.cke_prev & st_ff.s2[P_CKE] & ~st_ff.s2[P_CS];
   assign is_mrs = cmd_ok & ~st_ff.s2[P_RAS] & ~st_ff.s2[P_CAS] & ~st_ff.s2[P_WE];
   assign is_rd = cmd_ok & st_ff.s2[P_RAS] & ~st_ff.s2[P_CAS] & st_ff.s2[P_WE];
   assign is_wr = cmd_ok & st_ff.s2[P_RAS] & ~st_ff.s2[P_CAS] & ~st_ff.s2[P_WE];
   assign is_sre = rise & st_ff.cke_prev & ~st_ff.s2[P_CKE] & ~st_ff.s2[P_CS]
                   & ~st_ff.s2[P_RAS] & ~st_ff.s2[P_CAS] & st_ff.s2[P_WE];

   always_comb begin
      logic chop_now;
      logic [1:0] bl;
      chop_now = 1'b0;
      bl = st_ff.mr0[F_BL_LO+1:F_BL_LO];
      nxt_st = st_ff;
      nxt_st.s1 = pins;
      nxt_st.s2 = st_ff.s1;
      nxt_st.ck_prev = st_ff.s2[P_CK];
      nxt_st.wr_int = 1'b0;
      chop_now = (bl == BL_FIXED4) | ((bl == BL_OTF) & ~a[12]);

      if (rise) begin
         nxt_st.cke_prev = st_ff.s2[P_CKE];
         // power-down and self-refresh entry and exit
         if (is_sre) begin
            nxt_st.sref = 1'b1;
            if (!st_ff.mr1[F_DLL_DIS]) begin
               nxt_st.dll_on = 1'b0;
            end
         end else if (st_ff.cke_prev & ~st_ff.s2[P_CKE]) begin
            nxt_st.pdn = 1'b1;
         end
         if (~st_ff.cke_prev & st_ff.s2[P_CKE]) begin
            if (st_ff.sref) begin
               nxt_st.dll_on = ~st_ff.mr1[F_DLL_DIS];
            end
            nxt_st.sref = 1'b0;
            nxt_st.pdn = 1'b0;
         end
         // lock wait after a loop reset
         if (st_ff.dll_cnt != 16'h0000) begin
            nxt_st.dll_cnt = 16'(st_ff.dll_cnt - 16'h0001);
            if (st_ff.dll_cnt == 16'h0001) begin
               nxt_st.mr0[F_DLL_RST] = 1'b0;
               nxt_st.locked = st_ff.dll_on;
            end
         end
         // internal write start counter
         if (st_ff.wrc != 6'h00) begin
            nxt_st.wrc = 6'(st_ff.wrc - 6'h01);
            nxt_st.wr_int = (st_ff.wrc == 6'h01);
         end
         if (is_mrs) begin
            case (st_ff.s2[P_BA+2:P_BA])
               SEL_FIRST: begin
                  nxt_st.mr0 = a;
                  if (a[F_DLL_RST]) begin
                     nxt_st.dll_cnt = 16'(DLL_LOCK);
                     nxt_st.locked = 1'b0;
                  end
               end
               SEL_SECOND: begin
                  nxt_st.mr1 = a;
                  nxt_st.dll_on = ~a[F_DLL_DIS];
                  if (a[F_DLL_DIS]) begin
                     nxt_st.locked = 1'b0;
                  end
               end
               SEL_THIRD: begin
                  nxt_st.mr2 = a;
               end
               default: begin
               end
            endcase
         end
      end

      case (st_ff.st)
         ST_IDLE: begin
            if (is_rd) begin
               nxt_st.chop = chop_now;
               nxt_st.start = a[2:0];
               nxt_st.lat = rl;
               nxt_st.st = ST_RD_WAIT;
            end else if (is_wr) begin
               nxt_st.chop = chop_now;
               nxt_st.start = chop_now ? {a[2], 2'h0} : 3'h0;
               nxt_st.lat = wl;
               nxt_st.wrc = (bl == BL_FIXED4) ? 6'(wl + WR_INT_BC4)
                                              : 6'(wl + WR_INT_BL8);
               nxt_st.st = ST_WR_WAIT;
            end
         end
         ST_RD_WAIT, ST_WR_WAIT: begin
            if (rise) begin
               nxt_st.lat = 6'(st_ff.lat - 6'h01);
               if (st_ff.lat <= 6'h01) begin
                  nxt_st.slot = 4'h0;
                  nxt_st.st = (st_ff.st == ST_RD_WAIT) ? ST_RD_BURST : ST_WR_BURST;
               end
            end
         end
         ST_RD_BURST, ST_WR_BURST: begin
            if (edge_any) begin
               nxt_st.slot = 4'(st_ff.slot + 4'h1);
               if (st_ff.slot == 4'h7) begin
                  nxt_st.st = ST_IDLE;
               end
            end
         end
         default: begin
            nxt_st.st = ST_IDLE;
         end
      endcase

      // beat outputs, aligned with the order module
      nxt_st.bvalid = ((nxt_st.st == ST_RD_BURST) | (nxt_st.st == ST_WR_BURST))
                      & (~nxt_st.chop | (nxt_st.slot < 4'h4));
      nxt_st.bwrite = (nxt_st.st == ST_WR_BURST);
      nxt_st.oe_n = ~((nxt_st.st == ST_RD_BURST) & nxt_st.bvalid)
                    | nxt_st.mr1[F_QOFF];
      // termination, write value wins during write bursts
      nxt_st.term_wr = nxt_st.bvalid & nxt_st.bwrite & (rtt_wr != 2'h0);
      nxt_st.term_on = st_ff.s2[P_ODT] & (nxt_st.term_wr | (rtt_nom != 3'h0));
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= '{
            s1: '0, s2: '0, ck_prev: 1'b0, cke_prev: 1'b0,
            mr0: MR_RESET, mr1: MR_RESET, mr2: MR_RESET,
            st: ST_IDLE, lat: 6'h00, slot: 4'h0, start: 3'h0, chop: 1'b0,
            wrc: 6'h00, wr_int: 1'b0, dll_cnt: 16'h0000, dll_on: 1'b0,
            locked: 1'b0, sref: 1'b0, pdn: 1'b0, bvalid: 1'b0, bwrite: 1'b0,
            oe_n: 1'b1, term_on: 1'b0, term_wr: 1'b0
         };
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bo_slot = nxt_st.slot[2:0];

   dmc_burst_order u_order (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .start_i      (nxt_st.start),
      .interleave_i (st_ff.mr0[F_BTYPE]),
      .slot_i       (bo_slot),
      .beat_idx_o   (beat_idx_o)
   );

   assign beat_valid_o      = st_ff.bvalid;
   assign beat_write_o      = st_ff.bwrite;
   assign dq_oe_n_o         = st_ff.oe_n;
   assign internal_write_o  = st_ff.wr_int;
   assign term_on_o         = st_ff.term_on;
   assign term_use_wr_o     = st_ff.term_wr;
   assign term_nom_code_o   = rtt_nom;
   assign term_wr_code_o    = rtt_wr;
   assign drive_imp_o       = {st_ff.mr1[F_DIC1], st_ff.mr1[F_DIC0]};
   assign data_mask_en_o    = ~st_ff.mr1[F_TERMINATION_STROBE];
   assign dll_run_o         = st_ff.dll_on & ~st_ff.sref
                              & ~(st_ff.pdn & ~st_ff.mr0[F_PPD]);
   assign dll_locked_o      = st_ff.locked;
   assign slow_exit_o       = ~st_ff.mr0[F_PPD];
   assign write_level_o     = st_ff.mr1[F_WRLVL];
   assign test_mode_o       = st_ff.mr0[F_TEST];
   assign mode_reg_first_o  = st_ff.mr0;
   assign mode_reg_second_o = st_ff.mr1;
   assign mode_reg_third_o  = st_ff.mr2;
   assign read_latency_o    = rl;
   assign write_latency_o   = wl;

endmodule // dmc_mode_cfg
`default_nettype wire

// ==== verif/dmc_mode_cfg_assertions.sv ====
// port checker for the mode configuration block
// assumes binding to dmc_mode_cfg, one clock domain, async high reset
`timescale 1ns/1ns
`default_nettype none
module dmc_mode_cfg_assertions #(
   parameter int DLL_LOCK = 8
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // watched outputs
   input  wire logic        beat_valid_o,
   input  wire logic        beat_write_o,
   input  wire logic [2:0]  beat_idx_o,
   input  wire logic        dq_oe_n_o,
   input  wire logic        internal_write_o,
   input  wire logic        term_use_wr_o,
   input  wire logic [1:0]  term_wr_code_o,
   input  wire logic [1:0]  drive_imp_o,
   input  wire logic        data_mask_en_o,
   input  wire logic        dll_run_o,
   input  wire logic        dll_locked_o,
   input  wire logic        slow_exit_o,
   input  wire logic [15:0] mode_reg_first_o,
   input  wire logic [15:0] mode_reg_second_o,
   input  wire logic [15:0] mode_reg_third_o,
   input  wire logic [5:0]  read_latency_o,
   input  wire logic [5:0]  write_latency_o
);
   logic [5:0] cl;
   logic [5:0] al;
   always_comb begin
      cl = (mode_reg_first_o[2] ? 6'h0C : 6'h04) + {3'h0, mode_reg_first_o[6:4]};
      al = 6'h00;
      if (mode_reg_second_o[4:3] == 2'h1) al = cl - 6'h01;
      if (mode_reg_second_o[4:3] == 2'h2) al = cl - 6'h02;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_rl_sum: assert property (read_latency_o == cl + al)
      else $error("read latency wrong");
   a_wl_sum: assert property (write_latency_o == 6'h05 + {3'h0, mode_reg_third_o[5:3]} + al)
      else $error("write latency wrong");
   a_oe_read_only: assert property (!dq_oe_n_o |-> beat_valid_o && !beat_write_o && !mode_reg_second_o[12])
      else $error("drivers on outside read beat");
   a_drive_code: assert property (drive_imp_o == {mode_reg_second_o[5], mode_reg_second_o[1]})
      else $error("driver code wrong");
   a_mask_pin: assert property (data_mask_en_o != mode_reg_second_o[11])
      else $error("mask pin mode wrong");
   a_exit_sel: assert property (slow_exit_o != mode_reg_first_o[12])
      else $error("exit select wrong");
   a_dll_clear: assert property ($rose(dll_locked_o) |-> !mode_reg_first_o[8])
      else $error("loop reset bit not cleared");
   a_wr_order: assert property (beat_valid_o && beat_write_o && $past(beat_valid_o && beat_write_o)
      && beat_idx_o != $past(beat_idx_o) |-> beat_idx_o == $past(beat_idx_o) + 3'h1)
      else $error("write beat order wrong");
   a_iw_pulse: assert property ($rose(internal_write_o) |=> !internal_write_o)
      else $error("internal write not a pulse");
   a_wr_term: assert property (term_use_wr_o |-> beat_valid_o && beat_write_o
      && term_wr_code_o == mode_reg_third_o[10:9])
      else $error("write termination misused");
   a_dll_off: assert property (mode_reg_second_o[0] |-> !dll_run_o)
      else $error("loop runs while disabled");
   c_read: cover property ($fell(dq_oe_n_o));
   c_iwr: cover property ($rose(internal_write_o));
   c_lock: cover property ($rose(dll_locked_o));
   c_dll_off: cover property ($fell(dll_run_o));
endmodule // dmc_mode_cfg_assertions
bind dmc_mode_cfg dmc_mode_cfg_assertions #(.DLL_LOCK(DLL_LOCK)) u_chk (.clk_i, .rst_i,
   .beat_valid_o, .beat_write_o, .beat_idx_o, .dq_oe_n_o, .internal_write_o, .term_use_wr_o,
   .term_wr_code_o, .drive_imp_o, .data_mask_en_o, .dll_run_o, .dll_locked_o, .slow_exit_o,
   .mode_reg_first_o, .mode_reg_second_o, .mode_reg_third_o, .read_latency_o, .write_latency_o);
`default_nettype wire

// ==== verif/dmc_ctrl_model.sv ====
// memory controller model: free link clock and command issue
// assumes clk_i at 100 ns; link clock period 800 ns
`timescale 1ns/1ns
`default_nettype none
module dmc_ctrl_model (
   // system clock
   input  wire logic        clk_i,
   // memory pins
   output logic             ck_o,
   output logic             cke_o,
   output logic [3:0]       cmd_n_o,
   output logic             odt_o,
   output logic [2:0]       ba_o,
   output logic [15:0]      addr_o
);
   int t_cmd;
   int ph;
   initial begin
      ck_o = 1'b0;
      cke_o = 1'b0;
      cmd_n_o = 4'hF;
      odt_o = 1'b0;
      ba_o = 3'h0;
      addr_o = 16'h0000;
      ph = 0;
   end
   always @(negedge clk_i) begin
      ph <= (ph == 3) ? 0 : ph + 1;
      if (ph == 3) ck_o <= ~ck_o;
   end
   // full register value each time, no reserved codes
   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
      if (!cke_o) begin
         @(negedge ck_o);
         cke_o <= 1'b1;
         repeat (2) @(posedge ck_o);
      end
      @(negedge ck_o);
      cmd_n_o <= c;
      ba_o <= b;
      addr_o <= a;
      @(posedge ck_o);
      t_cmd = $time;
      @(negedge ck_o);
      cmd_n_o <= 4'hF;
      ba_o <= ~b;
      addr_o <= ~a;
   endtask
   // clock enable low before a reset
   task automatic cke_low();
      @(negedge ck_o);
      cke_o <= 1'b0;
   endtask
   // self-refresh entry: enable low with the refresh code
   task automatic sref();
      @(negedge ck_o);
      cke_o <= 1'b0;
      cmd_n_o <= 4'h1;
      @(negedge ck_o);
      cmd_n_o <= 4'hF;
   endtask
   task automatic set_odt(input logic v);
      @(negedge clk_i);
      odt_o <= v;
   endtask
endmodule // dmc_ctrl_model
`default_nettype wire

// ==== verif/dmc_mode_cfg_tb_top.sv ====
// self-checking bench for the mode configuration block
// assumes dmc_ctrl_model drives the pins; lock wait shortened to 8
`timescale 1ns/1ns
`default_nettype none
module dmc_mode_cfg_tb_top;
   import dmc_pkg::*;
   typedef struct {
      logic [15:0] mr0;
      logic [15:0] mr1;
      logic [3:0]  op;
      logic [15:0] adr;
      logic [31:0] seq;
      logic [7:0]  vld;
      int          lat;
      int          iw;
   } dmc_row_t;
   // test bit zero and one legal write recovery code in every row
   dmc_row_t rows [9] = '{
      '{16'h0010, 16'h0000, 4'h5, 16'h0005, 32'h56741230, 8'hFF, 5, 0},
      '{16'h0018, 16'h0000, 4'h5, 16'h0003, 32'h32107654, 8'hFF, 5, 0},
      '{16'h0012, 16'h0000, 4'h5, 16'h0006, 32'h67450000, 8'hF0, 5, 0},
      '{16'h0019, 16'h0000, 4'h5, 16'h1001, 32'h10325476, 8'hFF, 5, 0},
      '{16'h0019, 16'h0000, 4'h5, 16'h0007, 32'h76540000, 8'hF0, 5, 0},
      '{16'h0010, 16'h0008, 4'h5, 16'h0002, 32'h23016745, 8'hFF, 9, 0},
      '{16'h0010, 16'h0000, 4'h4, 16'h0005, 32'h01234567, 8'hFF, 5, 9},
      '{16'h0012, 16'h0000, 4'h4, 16'h0006, 32'h45670000, 8'hF0, 5, 7},
      '{16'h0011, 16'h0000, 4'h4, 16'h0004, 32'h45670000, 8'hF0, 5, 9}};
   logic clk_i, rst_i, beat_valid_o, beat_write_o, dq_oe_n_o, internal_write_o;
   logic term_on_o, term_use_wr_o, data_mask_en_o, dll_run_o, dll_locked_o;
   logic slow_exit_o, write_level_o, test_mode_o;
   logic [2:0] beat_idx_o, term_nom_code_o;
   logic [1:0] term_wr_code_o, drive_imp_o;
   logic [15:0] mode_reg_first_o, mode_reg_second_o, mode_reg_third_o;
   logic [5:0] read_latency_o, write_latency_o;
   wire logic ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, termination_control_pin_i;
   wire logic [2:0] ba_i;
   wire logic [15:0] addr_i;
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   int t_iw = 0;
   logic oe;
   logic seen;
   dmc_ctrl_model u_ctrl (.clk_i, .ck_o(ck_i), .cke_o(cke_i),
      .cmd_n_o({cs_n_i, ras_n_i, cas_n_i, we_n_i}), .odt_o(termination_control_pin_i),
      .ba_o(ba_i), .addr_o(addr_i));
   dmc_mode_cfg #(.DLL_LOCK(8)) u_dut (.clk_i, .rst_i, .ck_i, .cke_i, .cs_n_i, .ras_n_i,
      .cas_n_i, .we_n_i, .termination_control_pin_i, .ba_i, .addr_i, .beat_valid_o,
      .beat_write_o, .beat_idx_o, .dq_oe_n_o, .internal_write_o, .term_on_o, .term_use_wr_o,
      .term_nom_code_o, .term_wr_code_o, .drive_imp_o, .data_mask_en_o, .dll_run_o,
      .dll_locked_o, .slow_exit_o, .write_level_o, .test_mode_o, .mode_reg_first_o,
      .mode_reg_second_o, .mode_reg_third_o, .read_latency_o, .write_latency_o);
   initial clk_i = 1'b0;
   always #50 clk_i = ~clk_i;
   task automatic final_report();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chkv(input logic [15:0] g, input logic [15:0] e, input string m);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %0t %s got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic chkt(input int g, input int e, input string m);
      n_checks++;
      if (g != e) begin
         miscompares++;
         $display("BAD %0t %s got %0d want %0d", $time, m, g, e);
      end
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 9000) begin
         miscompares++;
         final_report();
      end
   end
   always @(negedge clk_i) if (internal_write_o === 1'b1) t_iw = $time;
   task automatic run(input dmc_row_t r);
      int t0;
      u_ctrl.cmd(4'h0, SEL_SECOND, r.mr1);
      u_ctrl.cmd(4'h0, SEL_FIRST, r.mr0);
      u_ctrl.cmd(r.op, 3'h0, r.adr);
      t0 = u_ctrl.t_cmd;
      for (int k = 0; k < 200 && beat_valid_o !== 1'b1; k++) @(negedge clk_i);
      chkt(($time - t0) / 800, r.lat, "first beat delay");
      for (int s = 0; s < 8; s++) begin
         chkv(beat_valid_o, r.vld[7-s], "beat valid");
         chkv(dq_oe_n_o, !(r.vld[7-s] && r.op == 4'h5), "driver enable");
         if (r.vld[7-s]) chkv(beat_idx_o, r.seq[28-4*s +: 3], "beat index");
         repeat (4) @(negedge clk_i);
      end
      repeat (16) @(negedge clk_i);
      if (r.op == 4'h4) chkt((t_iw - t0) / 800, r.iw, "internal write start");
   endtask
   initial begin
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      foreach (rows[i]) run(rows[i]);
      // clock enable drops before a mid-run reset, as at power-up
      u_ctrl.cke_low();
      rst_i = 1'b1;
      @(negedge clk_i);
      rst_i = 1'b0;
      chkv(mode_reg_first_o, MR_RESET, "first register reset");
      chkv({dq_oe_n_o, slow_exit_o, data_mask_en_o}, 16'h0007, "reset levels");
      chkv({read_latency_o, write_latency_o}, {4'h0, 6'h04, 6'h05}, "reset latency");
      // loop enable, loop reset, then wait for lock before any read
      u_ctrl.cmd(4'h0, SEL_SECOND, 16'h0000);
      u_ctrl.cmd(4'h0, SEL_FIRST, 16'h1110);
      for (int k = 0; k < 300 && dll_locked_o !== 1'b1; k++) @(negedge clk_i);
      chkv(mode_reg_first_o, 16'h1010, "loop reset bit");
      chkv({test_mode_o, slow_exit_o, dll_locked_o, dll_run_o}, 16'h0003, "fast exit, lock");
      u_ctrl.sref();
      repeat (8) @(negedge clk_i);
      chkv(dll_run_o, 1'b0, "loop off in self-refresh");
      u_ctrl.cmd(4'h7, 3'h0, 16'h0000);
      chkv(dll_run_o, 1'b1, "loop back on after exit");
      u_ctrl.cmd(4'h0, SEL_SECOND, 16'h1882);
      chkv(mode_reg_second_o, 16'h1882, "second register");
      chkv({write_level_o, drive_imp_o, data_mask_en_o}, 16'h000A, "drive bits");
      u_ctrl.cmd(4'h0, SEL_THIRD, 16'h0408);
      chkv({term_wr_code_o, write_latency_o}, {8'h00, 2'h2, 6'h06}, "third register");
      oe = 1'b1;
      seen = 1'b0;
      u_ctrl.cmd(4'h5, 3'h0, 16'h0000);
      repeat (120) begin
         @(negedge clk_i);
         oe = oe & dq_oe_n_o;
         seen = seen | beat_valid_o;
      end
      chkv({oe, seen}, 16'h0003, "outputs disabled");
      // write termination alone, nominal codes all zero
      u_ctrl.set_odt(1'b1);
      u_ctrl.cmd(4'h4, 3'h0, 16'h0000);
      for (int k = 0; k < 200 && beat_valid_o !== 1'b1; k++) @(negedge clk_i);
      chkv({term_on_o, term_use_wr_o, term_nom_code_o}, 16'h0018, "write term");
      repeat (40) @(negedge clk_i);
      // loop off: both terminations off first
      u_ctrl.set_odt(1'b0);
      u_ctrl.cmd(4'h0, SEL_THIRD, 16'h0008);
      u_ctrl.cmd(4'h0, SEL_SECOND, 16'h1881);
      chkv({dll_run_o, dll_locked_o, term_on_o, term_wr_code_o}, 16'h0000, "loop off");
      final_report();
   end
endmodule // dmc_mode_cfg_tb_top
`default_nettype wire
